// File: fsrd_defs.vh
// Purpose: shared constants of the serial flash read and identification decoder
// Assumes: one system clock; serial pins sampled through two-flop synchronisers
// Notes: opcodes, phase lengths, lane codes, data sources and states
`ifndef FSRD_DEFS_VH
`define FSRD_DEFS_VH

// read family opcodes
`define FSRD_OP_READ 8'h03
`define FSRD_OP_FAST 8'h0b
`define FSRD_OP_DUAL_OUT 8'h3b
`define FSRD_OP_QUAD_OUT 8'h6b
`define FSRD_OP_DUAL_IO 8'hbb
`define FSRD_OP_QUAD_IO 8'heb
`define FSRD_OP_QUAD_WORD 8'he7
`define FSRD_OP_QUAD_OCTAL 8'he3
// identification and security opcodes
`define FSRD_OP_POWER_DOWN 8'hb9
`define FSRD_OP_RELEASE_ID 8'hab
`define FSRD_OP_LEGACY_ID 8'h90
`define FSRD_OP_LEGACY_ID_DUAL 8'h92
`define FSRD_OP_LEGACY_ID_QUAD 8'h94
`define FSRD_OP_STD_ID 8'h9f
`define FSRD_OP_SEC_READ 8'h48
`define FSRD_OP_SEC_ERASE 8'h44
`define FSRD_OP_SEC_PROG 8'h42
`define FSRD_OP_UNIQUE_ID 8'h4b

// lanes per serial clock
`define FSRD_LANE_NONE 3'h0
`define FSRD_LANE_1 3'h1
`define FSRD_LANE_2 3'h2
`define FSRD_LANE_4 3'h4

// phase lengths in serial clocks, opcode as its last clock index
`define FSRD_CLK_OPCODE 6'h07
`define FSRD_CLK_ADDR_1 6'h18
`define FSRD_CLK_ADDR_2 6'h10
`define FSRD_CLK_ADDR_4 6'h08
`define FSRD_CLK_NONE 6'h00
`define FSRD_CLK_DUMMY_BYTE 6'h08
`define FSRD_CLK_DUMMY_QIO 6'h04
`define FSRD_CLK_DUMMY_WORD 6'h02

// data sources
`define FSRD_SRC_MEM 3'h0
`define FSRD_SRC_DEVID 3'h1
`define FSRD_SRC_MFDEV 3'h2
`define FSRD_SRC_STDID 3'h3
`define FSRD_SRC_UID 3'h4
`define FSRD_SRC_SECR 3'h5
`define FSRD_SRC_SECE 3'h6
`define FSRD_SRC_SECP 3'h7

// command states
`define FSRD_ST_OPCODE 3'h0
`define FSRD_ST_ADDR 3'h1
`define FSRD_ST_DUMMY 3'h2
`define FSRD_ST_DATA 3'h3
`define FSRD_ST_DOWN 3'h4
`define FSRD_ST_IGNORE 3'h5

// security register address fields
`define FSRD_SEC_HIGH_ZERO 8'h00
`define FSRD_SEC_SEL_LOW 4'h0
`define FSRD_SEC_SEL_HIGH 2'h0

// bit count of a byte and last byte index of the standard identification reply
`define FSRD_BYTE_BITS 4'h8
`define FSRD_STDID_LAST 3'h2
// pin synchroniser reset image: chip select high, others low
`define FSRD_SYNC_RST 6'h20
`endif

// File: fsrd_pin_sync.v
// Purpose: two-flop synchronisers for serial pins plus serial clock edge pulses
// Assumes: serial clock at most one eighth of the system clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`include "fsrd_defs.vh"
module fsrd_pin_sync
(
  input wire clock,
  input wire rstSyncB,
  input wire sclkPin,
  input wire chipSelBPin,
  input wire [3:0] ioPin,
  output wire sclkRise,
  output wire sclkFall,
  output wire chipSelB,
  output wire [3:0] ioIn
);
  wire [5:0] raw;
  wire [5:0] synced;
  reg sclkLast;
  // per-pin reset image, one bit per synchroniser
  localparam [5:0] SYNC_RST = `FSRD_SYNC_RST;

  assign raw = {chipSelBPin, sclkPin, ioPin};

  // one two-stage synchroniser per pin
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1)
    begin : gSync
      reg stage1;
      reg stage2;
      always @(posedge clock or negedge rstSyncB)
      begin
        if (!rstSyncB)
        begin
          stage1 <= SYNC_RST[i];
          stage2 <= SYNC_RST[i];
        end
        else
        begin
          stage1 <= raw[i];
          stage2 <= stage1;
        end
      end
      assign synced[i] = stage2;
    end
  endgenerate

  // edge detect on the settled serial clock
  always @(posedge clock or negedge rstSyncB)
  begin
    if (!rstSyncB)
      sclkLast <= 1'b0;
    else
      sclkLast <= synced[4];
  end

  assign sclkRise = synced[4] & ~sclkLast;
  assign sclkFall = ~synced[4] & sclkLast;
  assign chipSelB = synced[5];
  assign ioIn = synced[3:0];
endmodule

// File: fsrd_cmd_decoder.v
// Purpose: read-family and identification command decoder of a serial flash slave
// Assumes: array and security storage answer memData for memAddr within a few clocks
// Notes: serial clock oversampled; sclk must stay at or below clock/8
// Behaviour
// - dual output: bit 7 on line 1, bit 6 on line 0, highest pair first
// - dual address input: odd bit on line 1, even on line 0, msb pair first
// - quad output: bits 7..4 on lines 3..0, then bits 3..0
// - quad address input: 24 address plus 8 mode bits in eight clocks
// - release-power-down with three dummy bytes repeats device id until deselect
// - legacy id with address zero: maker id first, then device id
// - legacy id with address one: device id first, then maker id
// - security address: bits 23..16 zero, 15..8 select register, 7..0 byte
// - standard id: maker, memory type per command mode, capacity
// - opcode and single address sampled msb first on rising clock; select starts command
// - deasserting chip select after any bit ends a read cleanly
`timescale 1ns/1ps
`include "fsrd_defs.vh"
module fsrd_cmd_decoder
#(
  parameter [7:0] MAKER_ID = 8'ha5, // arbitrary value
  parameter [7:0] DEVICE_ID = 8'h3c, // arbitrary value
  parameter [7:0] TYPE_ONE_LINE = 8'h11, // arbitrary value
  parameter [7:0] TYPE_FOUR_LINE = 8'h22, // arbitrary value
  parameter [7:0] CAPACITY_ID = 8'h33, // arbitrary value
  parameter [63:0] UNIQUE_ID = 64'h0123456789abcdef // arbitrary value
)
(
  input wire clock,
  input wire rst_b,
  input wire sclkPin,
  input wire chipSelBPin,
  input wire [3:0] ioPin,
  output reg [3:0] ioOut,
  output reg [3:0] ioOe,
  input wire fourLineMode,
  input wire [7:0] memData,
  output reg [23:0] memAddr,
  output reg memRead,
  output reg secActive,
  output reg [1:0] secSel,
  output reg secEraseReq,
  output reg secProgReq,
  output reg [7:0] continuousReadModeBits,
  output reg powerDown
);
  reg rstMetaB;
  reg rstSyncB;
  wire sclkRise;
  wire sclkFall;
  wire chipSelB;
  wire [3:0] ioIn;
  reg [2:0] state;
  reg [5:0] clkCnt;
  reg [31:0] shIn;
  reg [2:0] addrLanes;
  reg [5:0] addrClks;
  reg [5:0] dummyClks;
  reg [2:0] dataLanes;
  reg [2:0] src;
  reg startDev;
  reg [7:0] txByte;
  reg [3:0] txLeft;
  reg [2:0] byteIdx;
  reg [2:0] dAddrLanes;
  reg [5:0] dAddrClks;
  reg [5:0] dDummy;
  reg [2:0] dDataLanes;
  reg [2:0] dSrc;
  reg dValid;
  reg [31:0] nextSh;
  reg [7:0] fetch;
  reg [7:0] cur;
  wire [7:0] opNow;
  wire [2:0] laneSel;
  wire [23:0] addrVal;
  wire [63:0] uidWord;
  wire secOk;
  wire needMem;

  // reset release through two flops
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMetaB <= 1'b0;
      rstSyncB <= 1'b0;
    end
    else
    begin
      rstMetaB <= 1'b1;
      rstSyncB <= rstMetaB;
    end
  end

  fsrd_pin_sync uSync
  (
    .clock(clock),
    .rstSyncB(rstSyncB),
    .sclkPin(sclkPin),
    .chipSelBPin(chipSelBPin),
    .ioPin(ioPin),
    .sclkRise(sclkRise),
    .sclkFall(sclkFall),
    .chipSelB(chipSelB),
    .ioIn(ioIn)
  );

  // opcode assembled msb first on line 0
  assign opNow = {shIn[6:0], ioIn[0]};
  assign laneSel = (state == `FSRD_ST_ADDR) ? addrLanes : `FSRD_LANE_1;

  // input shift per lane width
  always @*
  begin
    case (laneSel)
      `FSRD_LANE_2: nextSh = {shIn[29:0], ioIn[1], ioIn[0]};
      `FSRD_LANE_4: nextSh = {shIn[27:0], ioIn[3:0]};
      default: nextSh = {shIn[30:0], ioIn[0]};
    endcase
  end

  // multi-lane address carries mode bits in the low byte
  assign addrVal = (addrLanes == `FSRD_LANE_1) ? nextSh[23:0] : nextSh[31:8];
  assign secOk = (addrVal[23:16] == `FSRD_SEC_HIGH_ZERO) && (addrVal[11:8] == `FSRD_SEC_SEL_LOW)
    && (addrVal[15:14] == `FSRD_SEC_SEL_HIGH);
  assign uidWord = UNIQUE_ID << {byteIdx, 3'h0};
  assign needMem = (src == `FSRD_SRC_MEM) || (src == `FSRD_SRC_SECR);

  // command table: address lanes and clocks, dummy clocks, data lanes, source
  always @*
  begin
    dAddrLanes = `FSRD_LANE_1;
    dAddrClks = `FSRD_CLK_ADDR_1;
    dDummy = `FSRD_CLK_NONE;
    dDataLanes = `FSRD_LANE_1;
    dSrc = `FSRD_SRC_MEM;
    dValid = 1'b1;
    case (opNow)
      `FSRD_OP_READ: dSrc = `FSRD_SRC_MEM;
      `FSRD_OP_FAST: dDummy = `FSRD_CLK_DUMMY_BYTE;
      `FSRD_OP_DUAL_OUT:
      begin
        dDummy = `FSRD_CLK_DUMMY_BYTE;
        dDataLanes = `FSRD_LANE_2;
      end
      `FSRD_OP_QUAD_OUT:
      begin
        dDummy = `FSRD_CLK_DUMMY_BYTE;
        dDataLanes = `FSRD_LANE_4;
      end
      `FSRD_OP_DUAL_IO, `FSRD_OP_LEGACY_ID_DUAL:
      begin
        dAddrLanes = `FSRD_LANE_2;
        dAddrClks = `FSRD_CLK_ADDR_2;
        dDataLanes = `FSRD_LANE_2;
        dSrc = (opNow == `FSRD_OP_DUAL_IO) ? `FSRD_SRC_MEM : `FSRD_SRC_MFDEV;
      end
      `FSRD_OP_QUAD_IO, `FSRD_OP_QUAD_WORD, `FSRD_OP_QUAD_OCTAL, `FSRD_OP_LEGACY_ID_QUAD:
      begin
        dAddrLanes = `FSRD_LANE_4;
        dAddrClks = `FSRD_CLK_ADDR_4;
        dDataLanes = `FSRD_LANE_4;
        if (opNow == `FSRD_OP_QUAD_WORD)
          dDummy = `FSRD_CLK_DUMMY_WORD;
        else if (opNow != `FSRD_OP_QUAD_OCTAL)
          dDummy = `FSRD_CLK_DUMMY_QIO;
        dSrc = (opNow == `FSRD_OP_LEGACY_ID_QUAD) ? `FSRD_SRC_MFDEV : `FSRD_SRC_MEM;
      end
      `FSRD_OP_RELEASE_ID: dSrc = `FSRD_SRC_DEVID;
      `FSRD_OP_LEGACY_ID: dSrc = `FSRD_SRC_MFDEV;
      `FSRD_OP_STD_ID:
      begin
        dAddrLanes = `FSRD_LANE_NONE;
        dAddrClks = `FSRD_CLK_NONE;
        dSrc = `FSRD_SRC_STDID;
      end
      `FSRD_OP_SEC_READ:
      begin
        dDummy = `FSRD_CLK_DUMMY_BYTE;
        dSrc = `FSRD_SRC_SECR;
      end
      `FSRD_OP_SEC_ERASE, `FSRD_OP_SEC_PROG:
      begin
        dDataLanes = `FSRD_LANE_NONE;
        dSrc = (opNow == `FSRD_OP_SEC_ERASE) ? `FSRD_SRC_SECE : `FSRD_SRC_SECP;
      end
      `FSRD_OP_UNIQUE_ID:
      begin
        dDummy = `FSRD_CLK_DUMMY_BYTE;
        dSrc = `FSRD_SRC_UID;
      end
      default: dValid = 1'b0;
    endcase
  end

  // next outgoing byte from the selected source
  always @*
  begin
    case (src)
      `FSRD_SRC_DEVID: fetch = DEVICE_ID;
      `FSRD_SRC_MFDEV: fetch = (byteIdx[0] ^ startDev) ? DEVICE_ID : MAKER_ID;
      `FSRD_SRC_STDID:
      begin
        if (byteIdx == 3'h0)
          fetch = MAKER_ID;
        else if (byteIdx == 3'h1)
          fetch = fourLineMode ? TYPE_FOUR_LINE : TYPE_ONE_LINE;
        else
          fetch = CAPACITY_ID;
      end
      `FSRD_SRC_UID: fetch = uidWord[63:56];
      default: fetch = memData;
    endcase
    cur = (txLeft == 4'h0) ? fetch : txByte;
  end

  // command sequencer: rising edges take input, falling edges drive data
  always @(posedge clock or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      state <= `FSRD_ST_OPCODE;
      clkCnt <= 6'h00;
      shIn <= 32'h0;
      addrLanes <= `FSRD_LANE_1;
      addrClks <= `FSRD_CLK_NONE;
      dummyClks <= `FSRD_CLK_NONE;
      dataLanes <= `FSRD_LANE_1;
      src <= `FSRD_SRC_MEM;
      startDev <= 1'b0;
      txByte <= 8'h00;
      txLeft <= 4'h0;
      byteIdx <= 3'h0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      memAddr <= 24'h0;
      memRead <= 1'b0;
      secActive <= 1'b0;
      secSel <= 2'h0;
      secEraseReq <= 1'b0;
      secProgReq <= 1'b0;
      continuousReadModeBits <= 8'h00;
      powerDown <= 1'b0;
    end
    else
    begin
      memRead <= 1'b0;
      secEraseReq <= 1'b0;
      secProgReq <= 1'b0;
      if (chipSelB)
      begin
        // deselect ends any command at any bit
        state <= `FSRD_ST_OPCODE;
        clkCnt <= 6'h00;
        ioOe <= 4'h0;
        secActive <= 1'b0;
        if (state == `FSRD_ST_DOWN)
          powerDown <= 1'b1;
      end
      else if (sclkRise)
      begin
        case (state)
          `FSRD_ST_OPCODE:
          begin
            shIn <= nextSh;
            clkCnt <= clkCnt + 6'h01;
            if (clkCnt == `FSRD_CLK_OPCODE)
            begin
              clkCnt <= 6'h00;
              addrLanes <= dAddrLanes;
              addrClks <= dAddrClks;
              dummyClks <= dDummy;
              dataLanes <= dDataLanes;
              src <= dSrc;
              txLeft <= 4'h0;
              byteIdx <= 3'h0;
              if (opNow == `FSRD_OP_RELEASE_ID)
                powerDown <= 1'b0;
              if (powerDown && (opNow != `FSRD_OP_RELEASE_ID))
                state <= `FSRD_ST_IGNORE;
              else if (opNow == `FSRD_OP_POWER_DOWN)
                state <= `FSRD_ST_DOWN;
              else if (!dValid)
                state <= `FSRD_ST_IGNORE;
              else if (dAddrClks != `FSRD_CLK_NONE)
                state <= `FSRD_ST_ADDR;
              else
                state <= `FSRD_ST_DATA;
            end
          end
          `FSRD_ST_ADDR:
          begin
            shIn <= nextSh;
            clkCnt <= clkCnt + 6'h01;
            if (clkCnt == addrClks - 6'h01)
            begin
              clkCnt <= 6'h00;
              memAddr <= addrVal;
              startDev <= addrVal[0];
              secSel <= addrVal[13:12];
              if (addrLanes != `FSRD_LANE_1)
                continuousReadModeBits <= nextSh[7:0];
              if ((src >= `FSRD_SRC_SECR) && !secOk)
                state <= `FSRD_ST_IGNORE;
              else
              begin
                secEraseReq <= (src == `FSRD_SRC_SECE);
                secProgReq <= (src == `FSRD_SRC_SECP);
                secActive <= (src == `FSRD_SRC_SECR) && (dummyClks == `FSRD_CLK_NONE);
                if (dummyClks != `FSRD_CLK_NONE)
                  state <= `FSRD_ST_DUMMY;
                else if (dataLanes != `FSRD_LANE_NONE)
                  state <= `FSRD_ST_DATA;
                else
                  state <= `FSRD_ST_IGNORE;
              end
            end
          end
          `FSRD_ST_DUMMY:
          begin
            clkCnt <= clkCnt + 6'h01;
            if (clkCnt == dummyClks - 6'h01)
            begin
              clkCnt <= 6'h00;
              state <= `FSRD_ST_DATA;
              secActive <= (src == `FSRD_SRC_SECR);
            end
          end
          `FSRD_ST_DOWN: state <= `FSRD_ST_IGNORE;
          default: state <= state;
        endcase
      end
      else if (sclkFall && (state == `FSRD_ST_DATA))
      begin
        // drive the top lanes of the current byte
        case (dataLanes)
          `FSRD_LANE_2:
          begin
            ioOe <= 4'h3;
            ioOut <= {2'h0, cur[7], cur[6]};
          end
          `FSRD_LANE_4:
          begin
            ioOe <= 4'hf;
            ioOut <= cur[7:4];
          end
          default:
          begin
            ioOe <= 4'h2;
            ioOut <= {2'h0, cur[7], 1'b0};
          end
        endcase
        txByte <= cur << dataLanes;
        txLeft <= ((txLeft == 4'h0) ? `FSRD_BYTE_BITS : txLeft) - {1'b0, dataLanes};
        if (txLeft == 4'h0)
        begin
          // a new byte: advance address or id index
          if ((src == `FSRD_SRC_STDID) && (byteIdx == `FSRD_STDID_LAST))
            byteIdx <= 3'h0;
          else
            byteIdx <= byteIdx + 3'h1;
          if (needMem)
          begin
            memRead <= 1'b1;
            if (src == `FSRD_SRC_SECR)
              memAddr <= {memAddr[23:8], memAddr[7:0] + 8'h01};
            else
              memAddr <= memAddr + 24'h1;
          end
        end
      end
    end
  end
endmodule

// File: fsrd_cmd_decoder_assertions.sv
// Purpose: port checks for fsrd_cmd_decoder
// Assumes: one clock, rst_b async active low
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module fsrd_cmd_decoder_chk
(
  input wire clock,
  input wire rst_b,
  input wire sclkPin,
  input wire chipSelBPin,
  input wire [3:0] ioOut,
  input wire [3:0] ioOe,
  input wire memRead,
  input wire secEraseReq,
  input wire secProgReq,
  input wire [7:0] continuousReadModeBits,
  input wire powerDown
);
  // all checks on the system clock
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // lane enables come only in the three widths
  a_oe_legal: assert property (ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'h3 || ioOe == 4'hf)
    else $error("lane enable code not legal");
  // a deselected device lets go of the lines
  a_deselect_quiet: assert property (chipSelBPin [*8] |-> ioOe == 4'h0)
    else $error("lines driven while deselected");
  // drive only starts inside a frame
  a_drive_selected: assert property ($rose(ioOe != 4'h0) |-> !chipSelBPin)
    else $error("drive started outside a frame");
  // power-down answers nothing
  a_pd_quiet: assert property (powerDown |-> ioOe == 4'h0)
    else $error("drive while powered down");
  // data only moves after a falling serial clock
  a_out_stable: assert property ((ioOe != 4'h0 && sclkPin && $past(sclkPin, 5)) |-> $stable(ioOut))
    else $error("data moved during serial clock high");
  // one load pulse per byte
  a_mem_pulse: assert property (memRead |=> !memRead)
    else $error("memory load pulse too long");
  // security requests are single pulses
  a_req_pulse: assert property ((secEraseReq || secProgReq) |=> !(secEraseReq || secProgReq))
    else $error("security request too long");
  // mode byte is only captured inside a frame
  a_mode_framed: assert property (!$stable(continuousReadModeBits) |-> !chipSelBPin)
    else $error("mode byte changed outside a frame");
endmodule

// File: fsrd_host_model.sv
// Purpose: serial host controller driving the decoder
// Assumes: serial clock of 16 system clocks, changes at falling clock
// Notes: lines the host does not own toggle each serial clock
`timescale 1ns/1ps
module fsrd_host_model
(
  input wire clock,
  output reg sclkPin,
  output reg chipSelBPin,
  output reg [3:0] ioPin,
  input wire [3:0] ioOut,
  input wire [3:0] ioOe
);
  // idle: deselected, clock low
  initial
  begin
    sclkPin = 1'b0;
    chipSelBPin = 1'b1;
    ioPin = 4'h0;
  end
  // half of one serial clock
  task half;
    repeat (8) @(negedge clock);
  endtask
  // send n clocks of l lanes from the top of v
  task shiftOut(input [31:0] v, input [2:0] l, input [5:0] n);
    reg [31:0] sh;
    integer i;
    begin
      sh = v;
      for (i = 0; i < n; i = i + 1)
      begin
        sclkPin = 1'b0;
        case (l)
          3'h1: ioPin = {~ioPin[3:1], sh[31]};
          3'h2: ioPin = {~ioPin[3:2], sh[31:30]};
          default: ioPin = sh[31:28];
        endcase
        sh = sh << l;
        half;
        sclkPin = 1'b1;
        half;
      end
    end
  endtask
  // one frame: opcode, address, dummy, then rc data clocks read back
  task xfer(input [7:0] op, input [2:0] al, input [31:0] av, input [5:0] ac, input [5:0] dc,
    input [2:0] rl, input [6:0] rc, output [63:0] rv, output oeSeen);
    integer i;
    begin
      rv = 64'h0;
      oeSeen = 1'b0;
      chipSelBPin = 1'b0;
      half;
      shiftOut({op, 24'h0}, 3'h1, 6'h08);
      shiftOut(av, al, ac);
      shiftOut(32'h5a3c_96e1, 3'h4, dc);
      for (i = 0; i < rc; i = i + 1)
      begin
        sclkPin = 1'b0;
        ioPin = ~ioPin;
        half;
        oeSeen = oeSeen | (ioOe != 4'h0);
        case (rl)
          3'h1: rv = {rv[62:0], ioOut[1]};
          3'h2: rv = {rv[61:0], ioOut[1:0]};
          default: rv = {rv[59:0], ioOut};
        endcase
        sclkPin = 1'b1;
        half;
      end
      sclkPin = 1'b0;
      half;
      chipSelBPin = 1'b1;
      repeat (16) @(negedge clock);
    end
  endtask
endmodule

// File: tb_flash_read_id_command_decoder.sv
// Purpose: self-checking bench of fsrd_cmd_decoder
// Assumes: host model drives the serial pins
// Notes: storage answers address low byte xor 96h
`timescale 1ns/1ps
`include "fsrd_defs.vh"
module tb_flash_read_id_command_decoder;
  localparam [7:0] MK = 8'hc6; // arbitrary value
  localparam [7:0] DV = 8'h4e; // arbitrary value
  localparam [7:0] T1 = 8'h71; // arbitrary value
  localparam [7:0] T4 = 8'h74; // arbitrary value
  localparam [7:0] CP = 8'h2d; // arbitrary value
  localparam [63:0] UID = 64'hfedcba9813572468; // arbitrary value
  reg clock;
  reg rst_b;
  reg fourLineMode;
  wire sclkPin;
  wire chipSelBPin;
  wire [3:0] ioPin;
  wire [3:0] ioOut;
  wire [3:0] ioOe;
  wire [23:0] memAddr;
  wire memRead;
  wire secActive;
  wire [1:0] secSel;
  wire secEraseReq;
  wire secProgReq;
  wire [7:0] continuousReadModeBits;
  wire powerDown;
  wire [7:0] memData;
  reg [63:0] rv;
  reg oe;
  integer failures = 0;
  integer samplesChecked = 0;
  integer cycles = 0;
  integer nErase = 0;
  integer nProg = 0;
  integer nSec = 0;
  // storage model
  assign memData = memAddr[7:0] ^ 8'h96;
  fsrd_cmd_decoder #(.MAKER_ID(MK), .DEVICE_ID(DV), .TYPE_ONE_LINE(T1), .TYPE_FOUR_LINE(T4),
    .CAPACITY_ID(CP), .UNIQUE_ID(UID)) u_dut (.clock(clock), .rst_b(rst_b), .sclkPin(sclkPin),
    .chipSelBPin(chipSelBPin), .ioPin(ioPin), .ioOut(ioOut), .ioOe(ioOe), .fourLineMode(fourLineMode),
    .memData(memData), .memAddr(memAddr), .memRead(memRead), .secActive(secActive), .secSel(secSel),
    .secEraseReq(secEraseReq), .secProgReq(secProgReq), .continuousReadModeBits(continuousReadModeBits),
    .powerDown(powerDown));
  fsrd_host_model u_host (.clock(clock), .sclkPin(sclkPin), .chipSelBPin(chipSelBPin), .ioPin(ioPin),
    .ioOut(ioOut), .ioOe(ioOe));
  // clock and cycle ceiling
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (secEraseReq === 1'b1) nErase = nErase + 1;
    if (secProgReq === 1'b1) nProg = nProg + 1;
    if (secActive === 1'b1) nSec = nSec + 1;
    if (cycles == 90000)
    begin
      failures = failures + 1;
      summarize;
    end
  end
  // compare and count
  task check(input [63:0] seen, input [63:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // identification replies
  task idCases;
    begin
      u_host.xfer(`FSRD_OP_STD_ID, 3'h1, 32'h0, 6'h0, 6'h0, 3'h1, 7'd32, rv, oe);
      check(rv[31:0], {MK, T1, CP, MK});
      fourLineMode = 1'b1;
      u_host.xfer(`FSRD_OP_STD_ID, 3'h1, 32'h0, 6'h0, 6'h0, 3'h1, 7'd24, rv, oe);
      check(rv[23:0], {MK, T4, CP});
      fourLineMode = 1'b0;
      u_host.xfer(`FSRD_OP_LEGACY_ID, 3'h1, 32'h0, 6'd24, 6'h0, 3'h1, 7'd24, rv, oe);
      check(rv[23:0], {MK, DV, MK});
      u_host.xfer(`FSRD_OP_LEGACY_ID, 3'h1, 32'h100, 6'd24, 6'h0, 3'h1, 7'd24, rv, oe);
      check(rv[23:0], {DV, MK, DV});
      u_host.xfer(`FSRD_OP_UNIQUE_ID, 3'h1, 32'h0, 6'd24, 6'd8, 3'h1, 7'd64, rv, oe);
      check(rv, UID);
      $display("test id_reads done");
    end
  endtask
  // power-down refuses, release returns device id repeatedly
  task powerCase;
    begin
      u_host.xfer(`FSRD_OP_POWER_DOWN, 3'h1, 32'h0, 6'h0, 6'h0, 3'h1, 7'h0, rv, oe);
      check(powerDown, 1'b1);
      u_host.xfer(`FSRD_OP_STD_ID, 3'h1, 32'h0, 6'h0, 6'h0, 3'h1, 7'd8, rv, oe);
      check(oe, 1'b0);
      u_host.xfer(`FSRD_OP_RELEASE_ID, 3'h1, 32'h0, 6'd24, 6'h0, 3'h1, 7'd24, rv, oe);
      check({powerDown, rv[23:0]}, {1'b0, DV, DV, DV});
      $display("test power_down done");
    end
  endtask
  // one two-byte read of any read-family opcode
  task rd(input [7:0] op, input [2:0] al, input [5:0] ac, input [5:0] dc, input [2:0] rl,
    input [23:0] a, input [7:0] m);
    reg [6:0] rc;
    begin
      rc = 7'd16 / rl;
      u_host.xfer(op, al, {a, m}, ac, dc, rl, rc, rv, oe);
      check(rv[15:0], {a[7:0] ^ 8'h96, (a[7:0] + 8'h1) ^ 8'h96});
      if (al != 3'h1) check(continuousReadModeBits, m);
    end
  endtask
  // read family, then a read cut short mid-byte
  task readCases;
    begin
      rd(`FSRD_OP_READ, 3'h1, 6'd24, 6'h0, 3'h1, 24'h000120, 8'h0);
      rd(`FSRD_OP_FAST, 3'h1, 6'd24, 6'd8, 3'h1, 24'h000230, 8'h0);
      rd(`FSRD_OP_DUAL_OUT, 3'h1, 6'd24, 6'd8, 3'h2, 24'h01f341, 8'h0);
      rd(`FSRD_OP_QUAD_OUT, 3'h1, 6'd24, 6'd8, 3'h4, 24'h7a0052, 8'h0);
      rd(`FSRD_OP_DUAL_IO, 3'h2, 6'd16, 6'h0, 3'h2, 24'h1234a0, 8'h5a);
      rd(`FSRD_OP_QUAD_IO, 3'h4, 6'd8, 6'd4, 3'h4, 24'h345678, 8'ha6);
      rd(`FSRD_OP_QUAD_WORD, 3'h4, 6'd8, 6'd2, 3'h4, 24'h000f12, 8'h3c);
      rd(`FSRD_OP_QUAD_OCTAL, 3'h4, 6'd8, 6'h0, 3'h4, 24'h00ab40, 8'hc3);
      u_host.xfer(`FSRD_OP_FAST, 3'h1, 32'h00012300, 6'd24, 6'd8, 3'h1, 7'd3, rv, oe);
      check({oe, rv[2:0], ioOe}, {1'b1, 3'h5, 4'h0});
      $display("test reads done");
    end
  endtask
  // security register addressing, good and bad
  task secCase;
    begin
      u_host.xfer(`FSRD_OP_SEC_READ, 3'h1, 32'h00100500, 6'd24, 6'd8, 3'h1, 7'd8, rv, oe);
      check({secSel, rv[7:0], nSec != 0}, {2'h1, 8'h05 ^ 8'h96, 1'b1});
      u_host.xfer(`FSRD_OP_SEC_ERASE, 3'h1, 32'h00200000, 6'd24, 6'h0, 3'h1, 7'h0, rv, oe);
      check({nErase, secSel}, {32'h1, 2'h2});
      u_host.xfer(`FSRD_OP_SEC_ERASE, 3'h1, 32'h01300000, 6'd24, 6'h0, 3'h1, 7'h0, rv, oe);
      check(nErase, 32'h1);
      u_host.xfer(`FSRD_OP_SEC_PROG, 3'h1, 32'h00300000, 6'd24, 6'd8, 3'h1, 7'h0, rv, oe);
      check({nProg, secSel}, {32'h1, 2'h3});
      u_host.xfer(`FSRD_OP_SEC_READ, 3'h1, 32'h00400000, 6'd24, 6'd8, 3'h1, 7'd8, rv, oe);
      check(oe, 1'b0);
      $display("test security done");
    end
  endtask
  // counts and verdict
  task summarize;
    begin
      $display("checked %0d mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // reset then scenarios
  initial
  begin
    rst_b = 1'b0;
    fourLineMode = 1'b0;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    idCases;
    powerCase;
    readCases;
    secCase;
    summarize;
  end
endmodule
// checker beside the decoder
bind fsrd_cmd_decoder fsrd_cmd_decoder_chk u_chk (.clock(clock), .rst_b(rst_b), .sclkPin(sclkPin),
  .chipSelBPin(chipSelBPin), .ioOut(ioOut), .ioOe(ioOe), .memRead(memRead), .secEraseReq(secEraseReq),
  .secProgReq(secProgReq), .continuousReadModeBits(continuousReadModeBits), .powerDown(powerDown));
